// ==== design/eews_pkg.sv ====
// Shared constants and types of the two-wire EEPROM slave
package eews_pkg;
   // Clock and write cycle timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int WRITE_CYCLE_TIME_NS = 5000000;
   localparam int WRITE_CYCLES = (WRITE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Array geometry
   localparam int ADDR_W_4K = 9;
   localparam int ADDR_W_8K = 10;
   localparam int PAGE_W = 4;
   localparam int PAGE_BYTES = 16;
   // Device address word layout
   localparam logic [3:0] DEV_TYPE = 4'ha;
   localparam int DEV_TYPE_LSB = 4;
   localparam int RW_BIT = 0;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Synchroniser lanes
   localparam int PIN_W = 6;
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam int PIN_LOCK = 2;
   localparam int PIN_CS_LSB = 3;
   localparam logic [5:0] PIN_RST = 6'h03;
   typedef enum logic [2:0] {
      ST_IDLE, ST_DEVADDR, ST_WADDR, ST_WDATA, ST_RDATA, ST_RACK, ST_WCYCLE
   } eews_state_e;
endpackage

// ==== design/eews_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module eews_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Pins in, filtered levels out
   input wire logic [W-1:0] i_pin,
   output logic [W-1:0] o_val
);
   logic [W-1:0] s1_ff, s2_ff, s3_ff, val_ff, nxt_val;

   // Stage one feeds only stage two; the level moves once stages two and three agree
   always_comb begin
      nxt_val = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & val_ff);
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         s1_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
         val_ff <= RST_VAL;
      end else begin
         s1_ff <= i_pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         val_ff <= nxt_val;
      end
   end

   assign o_val = val_ff;
endmodule

// ==== design/eews_mem.sv ====
// Simple dual-port byte memory with registered read data
`timescale 1ns/100ps
module eews_mem #(
   parameter int AW = 4,
   parameter int DW = 8
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Write port
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [DW-1:0] i_wdata,
   // Read port
   input wire logic [AW-1:0] i_raddr,
   output logic [DW-1:0] o_rdata
);
   logic [DW-1:0] mem [2**AW];
   logic [DW-1:0] rdata_ff;

   // Storage has no reset, like a real array
   always_ff @(posedge i_mclk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= mem[i_raddr];
      end
   end

   assign o_rdata = rdata_ff;
endmodule

// ==== design/eews_top.sv ====
// Two-wire serial EEPROM slave: framing, addressing, page write and read sequencing
//
// Functional notes
// - SDA falling while SCL high is a start; every command begins with one.
// - SDA rising while SCL high is a stop; stop after a read gives standby.
// - SDA changes only while SCL low; changes with SCL high are framing.
// - Words are 8 bits; device pulls SDA low on ninth clock to acknowledge.
// - Standby after power-up, and after stop once internal work is done.
// - 4-Kbit build: 32 pages of 16 bytes, 9-bit word address.
// - 8-Kbit build: 64 pages of 16 bytes, 10-bit word address.
// - Address word's four top bits carry the fixed one-zero-one-zero pattern.
// - 4-Kbit: two select bits match pins 2 and 1; next bit is address MSB.
// - 8-Kbit: one select bit matches pin 2; next two are address MSBs.
// - Address word's last bit: high starts a read, low a write.
// - Match gives acknowledge; mismatch gives no acknowledge and back to standby.
// - Byte write: word address then one data byte, each acknowledged, then stop.
// - Stop ending a write starts a timed write cycle; bus ignored meanwhile.
// - Page write: up to fifteen more acknowledged bytes, then stop.
// - Only low four address bits increment; page end wraps to page start.
// - Over sixteen bytes wrap within the page, overwriting earlier ones.
// - Polling during write cycle is acknowledged only after the cycle ends.
// - Lock input low allows writes; high protects the whole array.
// - Sample SDA on SCL rise; change output SDA after SCL fall.
// - SDA is open drain: pull low or release only.
// - Address counter holds last address plus one; current read uses it.
// - Acknowledged reads continue with next byte, wrapping at array end.
`timescale 1ns/100ps
module eews_top #(
   parameter int P_ADDR_W = eews_pkg::ADDR_W_4K,
   parameter int P_WRITE_CYCLES = eews_pkg::WRITE_CYCLES
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_nrst,
   // Two-wire bus, SDA as open drain
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   // Straps
   input wire logic i_chip_select_pin_0,
   input wire logic i_chip_select_pin_1,
   input wire logic i_chip_select_pin_2,
   input wire logic i_array_lock_input,
   // Status
   output logic o_standby,
   output logic o_write_busy
);
   localparam int HI_W = P_ADDR_W - 8;
   localparam int WCNT_W = $clog2(P_WRITE_CYCLES + 1);
   localparam logic [WCNT_W-1:0] WCNT_LAST = WCNT_W'(P_WRITE_CYCLES - 1);
   localparam logic [WCNT_W-1:0] WCNT_PAGE = WCNT_W'(eews_pkg::PAGE_BYTES);

   logic [eews_pkg::PIN_W-1:0] pin_s;
   logic scl_s, sda_s, lock_s;
   logic [2:0] cs_s;
   eews_pkg::eews_state_e state_ff, nxt_state;
   logic scl_q_ff, sda_q_ff;
   logic [3:0] bcnt_ff, nxt_bcnt;
   logic [7:0] shift_ff, nxt_shift;
   logic [P_ADDR_W-1:0] addr_ff, nxt_addr, addr_inc, addr_inpage;
   logic [HI_W-1:0] pg_ff, nxt_pg;
   logic oe_ff, nxt_oe, ack_ff, nxt_ack, rw_ff, nxt_rw, mack_ff, nxt_mack;
   logic [eews_pkg::PAGE_BYTES-1:0] mask_ff, nxt_mask;
   logic [WCNT_W-1:0] wcnt_ff, nxt_wcnt;
   logic sda_o_ff, standby_ff, busy_ff;
   logic scl_rise, scl_fall, start_ev, stop_ev, byte_end, ack_end, dev_match, rx_state;
   logic buf_we, arr_we;
   logic [3:0] cidx;
   logic [7:0] buf_rdata, arr_rdata;

   // Every pin, straps included, goes through the filter; straps may be driven by logic
   eews_sync #(.W(eews_pkg::PIN_W), .RST_VAL(eews_pkg::PIN_RST)) u_sync (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_pin({i_chip_select_pin_2, i_chip_select_pin_1, i_chip_select_pin_0, i_array_lock_input, i_sda, i_scl}),
      .o_val(pin_s)
   );

   assign scl_s = pin_s[eews_pkg::PIN_SCL];
   assign sda_s = pin_s[eews_pkg::PIN_SDA];
   assign lock_s = pin_s[eews_pkg::PIN_LOCK];
   assign cs_s = pin_s[eews_pkg::PIN_CS_LSB +: 3];

   // Edge and framing detection on the filtered levels
   assign scl_rise = scl_s & ~scl_q_ff;
   assign scl_fall = ~scl_s & scl_q_ff;
   assign start_ev = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
   assign stop_ev = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
   assign rx_state = (state_ff == eews_pkg::ST_DEVADDR) || (state_ff == eews_pkg::ST_WADDR) ||
                     (state_ff == eews_pkg::ST_WDATA);
   assign byte_end = rx_state & scl_fall & (bcnt_ff == eews_pkg::BYTE_BITS) & ~ack_ff;
   assign ack_end = rx_state & scl_fall & ack_ff;
   // Unused select bits become address bits, so the compared width follows the size
   assign dev_match = (shift_ff[7:eews_pkg::DEV_TYPE_LSB] == eews_pkg::DEV_TYPE) &&
                      (shift_ff[3:HI_W+1] == cs_s[2:HI_W]);
   assign addr_inc = addr_ff + 1'b1;
   assign addr_inpage = {addr_ff[P_ADDR_W-1:eews_pkg::PAGE_W], addr_ff[3:0] + 4'h1};

   // Page buffer collects data; the array only changes during the write cycle
   assign buf_we = (state_ff == eews_pkg::ST_WDATA) & byte_end & ~lock_s;
   assign cidx = wcnt_ff[3:0] - 4'h1;
   assign arr_we = (state_ff == eews_pkg::ST_WCYCLE) && (wcnt_ff != '0) && (wcnt_ff <= WCNT_PAGE) &&
                   mask_ff[cidx];

   eews_mem #(.AW(eews_pkg::PAGE_W), .DW(8)) u_page (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_we(buf_we),
      .i_waddr(addr_ff[3:0]),
      .i_wdata(shift_ff),
      .i_raddr(wcnt_ff[3:0]),
      .o_rdata(buf_rdata)
   );

   // Array size follows the address width: 512 or 1024 bytes
   eews_mem #(.AW(P_ADDR_W), .DW(8)) u_array (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_we(arr_we),
      .i_waddr({addr_ff[P_ADDR_W-1:eews_pkg::PAGE_W], cidx}),
      .i_wdata(buf_rdata),
      .i_raddr(addr_ff),
      .o_rdata(arr_rdata)
   );

   always_comb begin
      nxt_state = state_ff;
      nxt_bcnt = bcnt_ff;
      nxt_shift = shift_ff;
      nxt_addr = addr_ff;
      nxt_pg = pg_ff;
      nxt_oe = oe_ff;
      nxt_ack = ack_ff;
      nxt_rw = rw_ff;
      nxt_mack = mack_ff;
      nxt_mask = mask_ff;
      nxt_wcnt = wcnt_ff;
      if (state_ff == eews_pkg::ST_WCYCLE) begin
         // Bus fully ignored until the cycle ends, so polls get no acknowledge
         nxt_oe = 1'b0;
         nxt_wcnt = wcnt_ff + 1'b1;
         if (wcnt_ff == WCNT_LAST) begin
            nxt_state = eews_pkg::ST_IDLE;
            nxt_mask = '0;
         end
      end else if (start_ev) begin
         nxt_state = eews_pkg::ST_DEVADDR;
         nxt_bcnt = '0;
         nxt_oe = 1'b0;
         nxt_ack = 1'b0;
      end else if (stop_ev) begin
         nxt_bcnt = '0;
         nxt_oe = 1'b0;
         nxt_ack = 1'b0;
         nxt_wcnt = '0;
         // Locked writes leave the mask empty, so no cycle starts
         if ((state_ff == eews_pkg::ST_WDATA) && (mask_ff != '0)) begin
            nxt_state = eews_pkg::ST_WCYCLE;
         end else begin
            nxt_state = eews_pkg::ST_IDLE;
         end
      end else begin
         case (state_ff)
            eews_pkg::ST_IDLE: begin
               nxt_oe = 1'b0;
            end
            eews_pkg::ST_DEVADDR, eews_pkg::ST_WADDR, eews_pkg::ST_WDATA: begin
               if (scl_rise && (bcnt_ff < eews_pkg::BYTE_BITS)) begin
                  nxt_shift = {shift_ff[6:0], sda_s};
                  nxt_bcnt = bcnt_ff + 4'h1;
               end else if (byte_end) begin
                  nxt_ack = 1'b1;
                  nxt_oe = 1'b1;
                  if (state_ff == eews_pkg::ST_DEVADDR) begin
                     if (dev_match) begin
                        nxt_pg = shift_ff[HI_W:1];
                        nxt_rw = shift_ff[eews_pkg::RW_BIT];
                     end else begin
                        nxt_state = eews_pkg::ST_IDLE;
                        nxt_oe = 1'b0;
                        nxt_ack = 1'b0;
                     end
                  end else if (state_ff == eews_pkg::ST_WADDR) begin
                     nxt_addr = {pg_ff, shift_ff};
                  end else begin
                     nxt_addr = addr_inpage;
                     if (!lock_s) begin
                        nxt_mask[addr_ff[3:0]] = 1'b1;
                     end
                  end
               end else if (ack_end) begin
                  nxt_ack = 1'b0;
                  nxt_oe = 1'b0;
                  nxt_bcnt = '0;
                  if (state_ff == eews_pkg::ST_DEVADDR) begin
                     if (rw_ff) begin
                        nxt_state = eews_pkg::ST_RDATA;
                        nxt_shift = arr_rdata;
                        nxt_oe = ~arr_rdata[7];
                     end else begin
                        nxt_state = eews_pkg::ST_WADDR;
                        nxt_mask = '0;
                     end
                  end else begin
                     nxt_state = eews_pkg::ST_WDATA;
                  end
               end
            end
            eews_pkg::ST_RDATA: begin
               if (scl_rise) begin
                  nxt_bcnt = bcnt_ff + 4'h1;
               end else if (scl_fall) begin
                  if (bcnt_ff < eews_pkg::BYTE_BITS) begin
                     nxt_oe = ~shift_ff[6];
                     nxt_shift = {shift_ff[6:0], 1'b0};
                  end else begin
                     nxt_oe = 1'b0;
                     nxt_addr = addr_inc;
                     nxt_bcnt = '0;
                     nxt_state = eews_pkg::ST_RACK;
                  end
               end
            end
            eews_pkg::ST_RACK: begin
               if (scl_rise) begin
                  nxt_mack = ~sda_s;
               end else if (scl_fall) begin
                  if (mack_ff) begin
                     nxt_state = eews_pkg::ST_RDATA;
                     nxt_shift = arr_rdata;
                     nxt_oe = ~arr_rdata[7];
                  end else begin
                     nxt_state = eews_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               nxt_state = eews_pkg::ST_IDLE;
               nxt_oe = 1'b0;
            end
         endcase
      end
   end

   // Device comes up in standby
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_ff <= eews_pkg::ST_IDLE;
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         bcnt_ff <= '0;
         shift_ff <= '0;
         addr_ff <= '0;
         pg_ff <= '0;
         oe_ff <= 1'b0;
         ack_ff <= 1'b0;
         rw_ff <= 1'b0;
         mack_ff <= 1'b0;
         mask_ff <= '0;
         wcnt_ff <= '0;
         sda_o_ff <= 1'b0;
         standby_ff <= 1'b1;
         busy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         scl_q_ff <= scl_s;
         sda_q_ff <= sda_s;
         bcnt_ff <= nxt_bcnt;
         shift_ff <= nxt_shift;
         addr_ff <= nxt_addr;
         pg_ff <= nxt_pg;
         oe_ff <= nxt_oe;
         ack_ff <= nxt_ack;
         rw_ff <= nxt_rw;
         mack_ff <= nxt_mack;
         mask_ff <= nxt_mask;
         wcnt_ff <= nxt_wcnt;
         sda_o_ff <= 1'b0;
         standby_ff <= (nxt_state == eews_pkg::ST_IDLE);
         busy_ff <= (nxt_state == eews_pkg::ST_WCYCLE);
      end
   end

   assign o_sda_out = sda_o_ff;
   assign o_sda_oe = oe_ff;
   assign o_standby = standby_ff;
   assign o_write_busy = busy_ff;

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);

   sequence s_dev_byte;
      (state_ff == eews_pkg::ST_DEVADDR) && byte_end;
   endsequence
   sequence s_rd_byte_end;
      (state_ff == eews_pkg::ST_RDATA) && scl_fall && (bcnt_ff == eews_pkg::BYTE_BITS);
   endsequence

   property p_ack_match;
      s_dev_byte and dev_match |=> oe_ff && ack_ff && (state_ff == eews_pkg::ST_DEVADDR);
   endproperty
   a_ack_match: assert property (p_ack_match) else $error("matching address not acknowledged");
   property p_nak_mismatch;
      s_dev_byte and !dev_match |=> !oe_ff ##1 o_standby;
   endproperty
   a_nak_mismatch: assert property (p_nak_mismatch) else $error("mismatch acknowledged");
   property p_oe_scl_low;
      // The drive decision was taken one edge earlier, so judge that edge's levels
      $changed(oe_ff) && !$past(start_ev) && !$past(stop_ev) |-> !$past(scl_s);
   endproperty
   a_oe_scl_low: assert property (p_oe_scl_low) else $error("SDA drive changed with SCL high");
   property p_start_abort;
      start_ev && (state_ff != eews_pkg::ST_WCYCLE) |=> (state_ff == eews_pkg::ST_DEVADDR) && (bcnt_ff == '0) && !oe_ff;
   endproperty
   a_start_abort: assert property (p_start_abort) else $error("start did not restart addressing");
   property p_stop_read;
      stop_ev && ((state_ff == eews_pkg::ST_RDATA) || (state_ff == eews_pkg::ST_RACK)) |=> o_standby;
   endproperty
   a_stop_read: assert property (p_stop_read) else $error("no standby after read stop");
   property p_wcycle_quiet;
      $rose(o_write_busy) |-> (o_write_busy && !oe_ff)[*8];
   endproperty
   a_wcycle_quiet: assert property (p_wcycle_quiet) else $error("bus driven in write cycle");
   property p_wcycle_end;
      (state_ff == eews_pkg::ST_WCYCLE) && (wcnt_ff == WCNT_LAST) |=> o_standby && !o_write_busy;
   endproperty
   a_wcycle_end: assert property (p_wcycle_end) else $error("write cycle length wrong");
   property p_page_wrap;
      (state_ff == eews_pkg::ST_WDATA) && byte_end |=> addr_ff == $past(addr_inpage);
   endproperty
   a_page_wrap: assert property (p_page_wrap) else $error("page address did not wrap in page");
   property p_lock;
      lock_s && (state_ff == eews_pkg::ST_WDATA) && byte_end |=> (mask_ff == $past(mask_ff));
   endproperty
   a_lock: assert property (p_lock) else $error("locked byte marked for commit");
   property p_lock_buf;
      buf_we |-> !lock_s;
   endproperty
   a_lock_buf: assert property (p_lock_buf) else $error("write stored while locked");
   property p_read_inc;
      s_rd_byte_end |=> addr_ff == $past(addr_inc) && (state_ff == eews_pkg::ST_RACK);
   endproperty
   a_read_inc: assert property (p_read_inc) else $error("read address not advanced");
endmodule

// ==== verification/eews_master_model.sv ====
// Two-wire bus master model: clock driver and open-drain data
`timescale 1ns/100ps
module eews_master_model #(
   parameter int T_PH = 48
) (
   // Bus
   output logic o_scl,
   output logic o_sda_oe,
   input wire logic i_sda
);
   // Clock stands high between frames, data released
   initial begin
      o_scl = 1'b1;
      o_sda_oe = 1'b0;
   end
   task automatic start();
      #T_PH o_sda_oe = 1'b0;
      #T_PH o_scl = 1'b1;
      #T_PH o_sda_oe = 1'b1;
      #T_PH o_scl = 1'b0;
   endtask
   task automatic stop();
      #T_PH o_sda_oe = 1'b1;
      #T_PH o_scl = 1'b1;
      #T_PH o_sda_oe = 1'b0;
      #T_PH;
   endtask
   // Data moves mid-way through the low phase, clear of the slave's late output edge
   task automatic xfer_bit(input logic b, output logic r);
      #T_PH o_sda_oe = ~b;
      #T_PH o_scl = 1'b1;
      #T_PH r = i_sda;
      o_scl = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
      xfer_bit(1'b1, r);
      ack = ~r;
   endtask
   task automatic recv_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(1'b1, r);
         d[i] = r;
      end
      xfer_bit(~more, r);
   endtask
   // Released clocks to free a stuck slave before the next start
   task automatic recover();
      logic r;
      repeat (9) xfer_bit(1'b1, r);
   endtask
endmodule

// ==== verification/tb_serial_eeprom_twowire_slave.sv ====
// Self-checking bench of the two-wire EEPROM slave
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb_serial_eeprom_twowire_slave;
   // Short write cycle keeps the run brief but outlasts one polling frame
   localparam int WCYC = 800;
   logic mclk, nrst, scl, m_oe, cs0, cs1, cs2, lock, sda_out, sda_oe, standby, busy, ack, r;
   logic [7:0] bd;
   logic [8:0] cur;
   logic [7:0] ref_mem [0:511];
   int fail_count, n_compared;
   wire sda;
   // Pull-up: any party pulling low wins
   assign sda = ~(m_oe | sda_oe);
   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;
   eews_top #(.P_ADDR_W(eews_pkg::ADDR_W_4K), .P_WRITE_CYCLES(WCYC)) i_dut (
      .i_mclk(mclk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
      .i_chip_select_pin_0(cs0), .i_chip_select_pin_1(cs1), .i_chip_select_pin_2(cs2),
      .i_array_lock_input(lock), .o_standby(standby), .o_write_busy(busy));
   eews_master_model i_mst (.o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda));
   task automatic test_done();
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   function automatic logic [7:0] dev_word(input logic [8:0] a, input logic rd);
      return {eews_pkg::DEV_TYPE, cs2, cs1, a[8], rd};
   endfunction
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 4 * WCYC) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 4 * WCYC) begin
         fail_count++;
         test_done();
      end
   endtask
   task automatic page_write(input logic [8:0] a, input int n);
      logic [7:0] d;
      i_mst.start();
      i_mst.send_byte(dev_word(a, 1'b0), ack);
      `CHK(ack, 1'b1)
      i_mst.send_byte(a[7:0], ack);
      `CHK(ack, 1'b1)
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         i_mst.send_byte(d, ack);
         `CHK(ack, 1'b1)
         if (!lock) ref_mem[{a[8:4], 4'(a[3:0] + i)}] = d;
      end
      i_mst.stop();
      repeat (20) @(posedge mclk);
      `CHK(busy, ~lock)
      if (!lock) begin
         i_mst.start();
         i_mst.send_byte(dev_word(a, 1'b0), ack);
         `CHK(ack, 1'b0)
         i_mst.stop();
         wait_idle();
         repeat (4) @(posedge mclk);
         `CHK(standby, 1'b1)
         i_mst.start();
         i_mst.send_byte(dev_word(a, 1'b0), ack);
         `CHK(ack, 1'b1)
         i_mst.stop();
      end
   endtask
   task automatic read_seq(input logic rnd, input logic [8:0] a, input int n);
      logic [7:0] d;
      if (rnd) begin
         i_mst.start();
         i_mst.send_byte(dev_word(a, 1'b0), ack);
         i_mst.send_byte(a[7:0], ack);
         cur = a;
      end
      i_mst.start();
      i_mst.send_byte(dev_word(cur, 1'b1), ack);
      `CHK(ack, 1'b1)
      for (int i = 0; i < n; i++) begin
         i_mst.recv_byte(i < n - 1, d);
         `CHK(d, ref_mem[cur])
         cur = cur + 9'h001;
      end
      i_mst.stop();
      repeat (10) @(posedge mclk);
      `CHK(standby, 1'b1)
   endtask
   initial begin
      void'($urandom(82447));
      nrst = 1'b0;
      lock = 1'b0;
      cs0 = 1'($urandom);
      cs1 = 1'($urandom);
      cs2 = 1'($urandom);
      fail_count = 0;
      n_compared = 0;
      cur = 9'h000;
      repeat (8) @(posedge mclk);
      `CHK(standby, 1'b1)
      `CHK(sda_oe, 1'b0)
      #1 nrst = 1'b1;
      repeat (10) @(posedge mclk);
      // Wrong type pattern, then each select bit flipped: all unanswered
      for (int k = 0; k < 3; k++) begin
         bd = dev_word(9'h000, 1'b0) ^ (8'h10 >> k);
         i_mst.start();
         i_mst.send_byte(bd, ack);
         `CHK(ack, 1'b0)
         i_mst.stop();
         `CHK(standby, 1'b1)
      end
      page_write({5'h1f, 4'($urandom)}, 18);
      page_write(9'h000, 1);
      // Start and four zero bits, then a second start arriving mid-byte
      i_mst.start();
      repeat (4) i_mst.xfer_bit(1'b0, r);
      i_mst.start();
      i_mst.send_byte(dev_word(9'h000, 1'b0), ack);
      `CHK(ack, 1'b1)
      i_mst.stop();
      i_mst.recover();
      read_seq(1'b1, 9'h1f0, 15);
      read_seq(1'b0, 9'h000, 2);
      @(posedge mclk);
      #1 lock = 1'b1;
      page_write(9'h000, 1);
      @(posedge mclk);
      #1 lock = 1'b0;
      read_seq(1'b1, 9'h000, 1);
      `CHK(sda_out, 1'b0)
      test_done();
   end
endmodule
